// ===== src/afe_spi_regs.vh
// Purpose: Offsets, field positions, reset values and codes of the
//          serial configuration port.
// Assumes: Plain Verilog-2005 includer.
// Notes:   Definitions only.
`ifndef AFE_SPI_REGS_VH
`define AFE_SPI_REGS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define AFE_ADDR_CONFIG      4'h0
`define AFE_ADDR_DAC         4'h1
`define AFE_ADDR_UNLOCK      4'hF

// ****************************************************************
// Reset values
// ****************************************************************
`define AFE_RST_CONFIG       8'h00
`define AFE_RST_DAC          8'h80
`define AFE_RST_UNLOCK       8'h00

// ****************************************************************
// Unlock key sequence
// ****************************************************************
`define AFE_KEY_FIRST        8'hFE
`define AFE_KEY_SECOND       8'hED

// ****************************************************************
// Command byte fields
// ****************************************************************
`define AFE_CMD_DIR_BIT      7
`define AFE_CMD_RSV_HI       6
`define AFE_CMD_RSV_LO       4
`define AFE_CMD_ADDR_HI      3

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define AFE_CFG_WR_MASK      8'h7F
`define AFE_CFG_PWR_HI       6
`define AFE_CFG_PWR_LO       5
`define AFE_CFG_EXTERNAL_FILTER_ROUTE     4
`define AFE_CFG_CM_SEL       3
`define AFE_CFG_SECOND_STAGE_GAIN_SEL_HI     2
`define AFE_CFG_SECOND_STAGE_GAIN_SEL_LO     1
`define AFE_CFG_FIRST_STAGE_GAIN_SEL        0

// ****************************************************************
// Gain values
// ****************************************************************
`define AFE_FIRST_STAGE_GAIN_SEL_HIGH       8'hFA
`define AFE_FIRST_STAGE_GAIN_SEL_LOW        8'h2A
`define AFE_SECOND_STAGE_GAIN_SEL_X4         6'h04
`define AFE_SECOND_STAGE_GAIN_SEL_X8         6'h08
`define AFE_SECOND_STAGE_GAIN_SEL_X16        6'h10
`define AFE_SECOND_STAGE_GAIN_SEL_X32        6'h20

// ****************************************************************
// Frame bit counts
// ****************************************************************
`define AFE_CMD_LAST_BIT     4'h7
`define AFE_FRAME_BITS       5'h10

`endif

// ===== src/afe_edge_sync.v
// Purpose: Two-flop synchroniser with edge detection for pin inputs.
// Assumes: Input asynchronous to i_mclk.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/10ps

module afe_edge_sync
#(
  parameter [0:0] RST_VAL = 1'b1
)
(
  input  wire i_mclk,
  input  wire i_sys_rst,
  input  wire i_pin,
  output reg  o_level,
  output reg  o_rise,
  output reg  o_fall
);

  reg meta;
  reg sync;

  // Reset to the pin's idle level so no false edge follows reset
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      meta    <= RST_VAL;
      sync    <= RST_VAL;
      o_level <= RST_VAL;
      o_rise  <= 1'b0;
      o_fall  <= 1'b0;
    end
    else
    begin
      meta    <= i_pin;
      sync    <= meta;
      o_level <= sync;
      o_rise  <= sync & ~o_level;
      o_fall  <= ~sync & o_level;
    end
  end

endmodule // afe_edge_sync

// ===== src/afe_spi_config_port.v
// Purpose: Three-wire serial configuration port and register bank of a
//          thermopile front end.
// Assumes: Serial clock at most a tenth of i_mclk; pins are synchronised.
// Notes:   Output-enable pin is low while the device drives the data pin.
`timescale 1ns/10ps

`include "afe_spi_regs.vh"

// Contract
// - First gain bit selects gain 250 when clear, 42 when set.
// - Second gain field maps 00..11 to gains 4, 8, 16, 32.
// - Route bit clear feeds stage two directly; set routes to filter pins.
// - Common-mode bit selects 1.15 V or 2.59 V bias.
// - Only writes accepted after power-up; reads need unlocked mode.
// - Chip select release aborts an incomplete transaction.
// - Chip select assertion returns the machine to instruction state.
// - With chip select tied low, frames are counted by clocks alone.
// - Write is one command byte then one data byte, stored.
// - Command byte: bit 7 direction, bits 6:4 zero, bits 3:0 address.
// - In read mode the addressed register drives the data pin; the unlock register reads as 0x00.
// - Data line ownership turns around within half a serial clock.
// - Writes 0xFE then 0xED unlock reads; any other value locks.
// - Unlimited reads allowed until another unlock register write.
// - Byte-wide registers at unique addresses; config only by writes.
// - Config and DAC reset to 0x00 and 0x80; unlock register to 0.
// - Config bits: 7 zero, 6:5 power, 4 route, 3 cm, 2:1, 0 gains.
// - Offset DAC code shifts output per step; 128 is zero shift.
module afe_spi_config_port
(
  input  wire       i_mclk,
  input  wire       i_sys_rst,
  input  wire       i_sclk,
  input  wire       i_chip_select_n,
  input  wire       i_sdio,
  output reg        o_sdio,
  output reg        o_sdio_oe_n,
  output reg        o_first_stage_gain_sel,
  output reg  [1:0] o_second_stage_gain_sel,
  output reg  [7:0] o_first_stage_gain,
  output reg  [5:0] o_second_stage_gain,
  output reg        o_external_filter_route,
  output reg        o_direct_stage_link,
  output reg        o_common_mode_select,
  output reg  [1:0] o_amp_power_en,
  output reg  [7:0] o_offset_dac_code,
  output reg        o_read_mode
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [1:0] ST_CMD  = 2'b00;
  localparam [1:0] ST_DATA = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg  [7:0] analog_path_config;
  reg  [7:0] offset_dac_setting;
  reg  [7:0] read_unlock_key_reg;
  wire [7:0] rd_byte;
  reg  [1:0] state;
  reg  [3:0] bit_cnt;
  reg  [7:0] shift;
  reg        cmd_read;
  reg  [3:0] cmd_addr;
  reg        cmd_ok;
  reg  [7:0] rd_shift;
  reg        rd_active;

  wire       sclk_lvl;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_lvl;
  wire       cs_rise;
  wire       cs_fall;
  wire       sdio_lvl;
  wire [7:0] next_shift;

  assign next_shift = {shift[6:0], sdio_lvl};

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  afe_edge_sync #(.RST_VAL (1'b1)) u_sclk_sync
  (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_sclk),
    .o_level   (sclk_lvl),
    .o_rise    (sclk_rise),
    .o_fall    (sclk_fall)
  );

  afe_edge_sync #(.RST_VAL (1'b1)) u_cs_sync
  (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_chip_select_n),
    .o_level   (cs_lvl),
    .o_rise    (cs_rise),
    .o_fall    (cs_fall)
  );

  afe_edge_sync #(.RST_VAL (1'b1)) u_sdio_sync
  (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_sdio),
    .o_level   (sdio_lvl),
    .o_rise    (),
    .o_fall    ()
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [7:0] read_mux;
    input [3:0] addr;
    input [7:0] cfg;
    input [7:0] dac;
    begin
      case (addr)
        `AFE_ADDR_CONFIG: read_mux = cfg;
        `AFE_ADDR_DAC:    read_mux = dac;
        default:          read_mux = 8'h00;
      endcase
    end
  endfunction

  function [5:0] second_stage_gain_sel_of;
    input [1:0] code;
    begin
      case (code)
        2'b00:   second_stage_gain_sel_of = `AFE_SECOND_STAGE_GAIN_SEL_X4;
        2'b01:   second_stage_gain_sel_of = `AFE_SECOND_STAGE_GAIN_SEL_X8;
        2'b10:   second_stage_gain_sel_of = `AFE_SECOND_STAGE_GAIN_SEL_X16;
        default: second_stage_gain_sel_of = `AFE_SECOND_STAGE_GAIN_SEL_X32;
      endcase
    end
  endfunction

  assign rd_byte = read_mux(cmd_addr, analog_path_config,
                            offset_dac_setting);

  // ****************************************************************
  // Serial frame machine
  // ****************************************************************
  // Tied-low chip select keeps cs_lvl low, so frames run on count alone
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state               <= ST_CMD;
      bit_cnt             <= 4'h0;
      shift               <= 8'h00;
      cmd_read            <= 1'b0;
      cmd_addr            <= 4'h0;
      cmd_ok              <= 1'b0;
      analog_path_config  <= `AFE_RST_CONFIG;
      offset_dac_setting  <= `AFE_RST_DAC;
      read_unlock_key_reg <= `AFE_RST_UNLOCK;
      o_read_mode         <= 1'b0;
    end
    else if (cs_rise | cs_fall)
    begin
      // Any chip select edge drops a partial frame without a write
      state   <= ST_CMD;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
    end
    else if (!cs_lvl && sclk_rise)
    begin
      shift   <= next_shift;
      bit_cnt <= bit_cnt + 4'h1;
      case (state)
        ST_CMD:
        begin
          if (bit_cnt == `AFE_CMD_LAST_BIT)
          begin
            cmd_read <= next_shift[`AFE_CMD_DIR_BIT];
            cmd_addr <= next_shift[`AFE_CMD_ADDR_HI:0];
            // Nonzero reserved bits void the frame as a safety net
            cmd_ok   <= (next_shift[`AFE_CMD_RSV_HI:`AFE_CMD_RSV_LO]
                         == 3'b000);
            bit_cnt  <= 4'h0;
            state    <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (bit_cnt == `AFE_CMD_LAST_BIT)
          begin
            bit_cnt <= 4'h0;
            // Only one data byte per frame; chip select tied low restarts
            state   <= cs_lvl ? ST_DONE : ST_CMD;
            if (cmd_ok && !cmd_read)
            begin
              case (cmd_addr)
                `AFE_ADDR_CONFIG:
                  analog_path_config <= next_shift
                                        & `AFE_CFG_WR_MASK;
                `AFE_ADDR_DAC:
                  offset_dac_setting <= next_shift;
                `AFE_ADDR_UNLOCK:
                begin
                  // Stored key survives writes to other registers between
                  read_unlock_key_reg <= next_shift;
                  o_read_mode <= (read_unlock_key_reg == `AFE_KEY_FIRST) &&
                                 (next_shift == `AFE_KEY_SECOND);
                end
                default:
                  read_unlock_key_reg <= read_unlock_key_reg;
              endcase
            end
          end
        end
        ST_DONE:
          bit_cnt <= 4'h0;
        default:
          state <= ST_CMD;
      endcase
    end
  end

  // ****************************************************************
  // Read data driver
  // ****************************************************************
  // Launches on falling edges so the master samples on rising edges
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rd_shift    <= 8'h00;
      rd_active   <= 1'b0;
      o_sdio      <= 1'b0;
      o_sdio_oe_n <= 1'b1;
    end
    else if (cs_rise | cs_fall)
    begin
      rd_active   <= 1'b0;
      o_sdio_oe_n <= 1'b1;
    end
    else if (!cs_lvl && sclk_fall)
    begin
      if (state == ST_DATA && bit_cnt == 4'h0 && !rd_active &&
          cmd_read && cmd_ok && o_read_mode)
      begin
        // Turnaround on the falling edge after the eighth bit
        rd_active   <= 1'b1;
        o_sdio_oe_n <= 1'b0;
        o_sdio      <= rd_byte[7];
        rd_shift    <= {rd_byte[6:0], 1'b0};
      end
      else if (rd_active && state == ST_DATA)
      begin
        o_sdio   <= rd_shift[7];
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
      else
      begin
        rd_active   <= 1'b0;
        o_sdio_oe_n <= 1'b1;
      end
    end
    else if (rd_active && state != ST_DATA && sclk_rise)
    begin
      // Release right after the sixteenth rising edge
      rd_active   <= 1'b0;
      o_sdio_oe_n <= 1'b1;
    end
    else if (rd_active && state != ST_DATA && sclk_lvl)
    begin
      rd_active   <= 1'b0;
      o_sdio_oe_n <= 1'b1;
    end
  end

  // ****************************************************************
  // Analog control outputs
  // ****************************************************************
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_first_stage_gain_sel  <= 1'b0;
      o_second_stage_gain_sel <= 2'b00;
      o_first_stage_gain      <= `AFE_FIRST_STAGE_GAIN_SEL_HIGH;
      o_second_stage_gain     <= `AFE_SECOND_STAGE_GAIN_SEL_X4;
      o_external_filter_route <= 1'b0;
      o_direct_stage_link     <= 1'b1;
      o_common_mode_select    <= 1'b0;
      o_amp_power_en          <= 2'b00;
      o_offset_dac_code       <= `AFE_RST_DAC;
    end
    else
    begin
      o_first_stage_gain_sel  <= analog_path_config[`AFE_CFG_FIRST_STAGE_GAIN_SEL];
      o_first_stage_gain      <= analog_path_config[`AFE_CFG_FIRST_STAGE_GAIN_SEL] ?
                                 `AFE_FIRST_STAGE_GAIN_SEL_LOW : `AFE_FIRST_STAGE_GAIN_SEL_HIGH;
      o_second_stage_gain_sel <=
        analog_path_config[`AFE_CFG_SECOND_STAGE_GAIN_SEL_HI:`AFE_CFG_SECOND_STAGE_GAIN_SEL_LO];
      o_second_stage_gain     <= second_stage_gain_sel_of(
        analog_path_config[`AFE_CFG_SECOND_STAGE_GAIN_SEL_HI:`AFE_CFG_SECOND_STAGE_GAIN_SEL_LO]);
      o_external_filter_route <= analog_path_config[`AFE_CFG_EXTERNAL_FILTER_ROUTE];
      o_direct_stage_link     <= ~analog_path_config[`AFE_CFG_EXTERNAL_FILTER_ROUTE];
      o_common_mode_select    <= analog_path_config[`AFE_CFG_CM_SEL];
      o_amp_power_en          <=
        analog_path_config[`AFE_CFG_PWR_HI:`AFE_CFG_PWR_LO];
      o_offset_dac_code       <= offset_dac_setting;
    end
  end

endmodule // afe_spi_config_port

// ===== verif/afe_spi_config_port_properties.sv
// Purpose: Port-level properties of the serial configuration port.
// Assumes: Sees only the top-level ports.
// Notes:   Bound into every instance of the port.
`timescale 1ns/10ps

module afe_spi_config_port_chk
(
  input wire       i_mclk,
  input wire       i_sys_rst,
  input wire       i_sclk,
  input wire       i_chip_select_n,
  input wire       o_sdio,
  input wire       o_sdio_oe_n,
  input wire       o_first_stage_gain_sel,
  input wire [1:0] o_second_stage_gain_sel,
  input wire [7:0] o_first_stage_gain,
  input wire [5:0] o_second_stage_gain,
  input wire       o_external_filter_route,
  input wire       o_direct_stage_link,
  input wire [7:0] o_offset_dac_code,
  input wire       o_read_mode
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  // ***********************
  // Sequences
  // ***********************
  // Eight cycles covers pin sync plus the release delay
  sequence s_cs_idle;
    i_chip_select_n [*8];
  endsequence
  sequence s_turn;
    !i_sclk && !i_chip_select_n;
  endsequence

  // ***********************
  // Properties
  // ***********************
  chk_first_stage_gain_sel_map: assert property (
    $stable(o_first_stage_gain_sel) |->
    o_first_stage_gain == (o_first_stage_gain_sel ? 8'h2A : 8'hFA))
    else $error("first gain wrong");
  chk_second_stage_gain_sel_map: assert property (
    $stable(o_second_stage_gain_sel) |->
    o_second_stage_gain == (6'h04 << o_second_stage_gain_sel))
    else $error("second gain wrong");
  chk_route_link: assert property (
    $stable(o_external_filter_route) |->
    o_direct_stage_link == !o_external_filter_route)
    else $error("route and link disagree");
  chk_locked_quiet: assert property (
    !o_read_mode |-> o_sdio_oe_n)
    else $error("data driven while locked");
  chk_cs_release: assert property (
    s_cs_idle |-> o_sdio_oe_n)
    else $error("data driven without select");
  chk_idle_hold: assert property (
    s_cs_idle |=> $stable(o_offset_dac_code) &&
    $stable(o_first_stage_gain_sel))
    else $error("config moved while idle");
  chk_drive_start: assert property (
    $fell(o_sdio_oe_n) |-> s_turn)
    else $error("turnaround out of place");
  chk_launch_fall: assert property (
    !o_sdio_oe_n && $changed(o_sdio) |-> !i_sclk)
    else $error("read bit moved with clock high");
  chk_mode_at_end: assert property (
    $changed(o_read_mode) |-> i_sclk)
    else $error("read mode moved mid frame");
endmodule // afe_spi_config_port_chk

bind afe_spi_config_port afe_spi_config_port_chk i_afe_spi_config_port_chk
(
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk),
  .i_chip_select_n(i_chip_select_n), .o_sdio(o_sdio),
  .o_sdio_oe_n(o_sdio_oe_n),
  .o_first_stage_gain_sel(o_first_stage_gain_sel),
  .o_second_stage_gain_sel(o_second_stage_gain_sel),
  .o_first_stage_gain(o_first_stage_gain),
  .o_second_stage_gain(o_second_stage_gain),
  .o_external_filter_route(o_external_filter_route),
  .o_direct_stage_link(o_direct_stage_link),
  .o_offset_dac_code(o_offset_dac_code), .o_read_mode(o_read_mode)
);

// ===== verif/afe_spi_master.sv
// Purpose: Serial master model driving the configuration port.
// Assumes: Link period of 48 ns, twelve mclk cycles.
// Notes:   All pin changes happen on mclk falling edges.
`timescale 1ns/10ps

module afe_spi_master
(
  input  wire i_mclk,
  input  wire i_sdio,
  output reg  o_sclk,
  output reg  o_chip_select_n,
  output reg  o_sdio
);
  localparam int HALF = 6;

  initial
  begin
    o_sclk = 1'b1;
    o_chip_select_n = 1'b1;
    o_sdio = 1'b0;
  end

  task automatic wait_half;
    repeat (HALF) @(negedge i_mclk);
  endtask

  // Short nbits with a released select makes an aborted frame
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wdat,
                       input int nbits, input bit keep,
                       output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {cmd, wdat};
    rdat = 8'h00;
    @(negedge i_mclk);
    o_chip_select_n = 1'b0;
    wait_half();
    for (int i = 0; i < nbits; i++)
    begin
      o_sclk = 1'b0;
      // Released line toggles so no stale bit can pass for data
      o_sdio = (cmd[7] && i >= 8) ? ~o_sdio : sh[15-i];
      wait_half();
      if (i >= 8)
        rdat = {rdat[6:0], i_sdio};
      o_sclk = 1'b1;
      wait_half();
    end
    if (!keep)
      o_chip_select_n = 1'b1;
    wait_half();
    wait_half();
  endtask
endmodule // afe_spi_master

// ===== verif/afe_spi_config_port_tb_top.sv
// Purpose: Self-checking bench for the serial configuration port.
// Assumes: Master model owns the serial pins.
// Notes:   Expected values come from the register map only.
`timescale 1ns/10ps

module afe_spi_config_port_tb_top;
  logic       i_mclk;
  logic       i_sys_rst;
  logic       sclk;
  logic       cs_n;
  logic       m_sdio;
  logic       d_sdio;
  logic       line;
  logic       oe_n;
  logic       g1_sel;
  logic [1:0] g2_sel;
  logic [7:0] g1;
  logic [5:0] g2;
  logic       route;
  logic       direct;
  logic       cm_sel;
  logic [1:0] pwr;
  logic [7:0] dac;
  logic       rd_mode;
  logic [7:0] rdat;
  logic [7:0] v;
  bit         keep;
  logic       drove;
  int         miscompares;
  int         cmp_count;

  // Device owns the line only while its enable is low
  assign line = oe_n ? m_sdio : d_sdio;

  // Remembers whether the device ever took the line since reset
  always @(posedge i_mclk)
  begin
    if (i_sys_rst)
      drove <= 1'b0;
    else if (oe_n !== 1'b1)
      drove <= 1'b1;
  end

  afe_spi_config_port i_afe_spi_config_port
  (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sclk(sclk),
    .i_chip_select_n(cs_n), .i_sdio(line), .o_sdio(d_sdio),
    .o_sdio_oe_n(oe_n), .o_first_stage_gain_sel(g1_sel),
    .o_second_stage_gain_sel(g2_sel), .o_first_stage_gain(g1),
    .o_second_stage_gain(g2), .o_external_filter_route(route),
    .o_direct_stage_link(direct), .o_common_mode_select(cm_sel),
    .o_amp_power_en(pwr), .o_offset_dac_code(dac),
    .o_read_mode(rd_mode)
  );

  afe_spi_master i_afe_spi_master
  (
    .i_mclk(i_mclk), .i_sdio(line), .o_sclk(sclk),
    .o_chip_select_n(cs_n), .o_sdio(m_sdio)
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_afe_spi_master.frame({4'h0, a}, d, 16, keep, rdat);
  endtask

  task automatic rd(input logic [3:0] a);
    i_afe_spi_master.frame({4'h8, a}, 8'h00, 16, keep, rdat);
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is near 20 us; this only cuts a hang
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    i_sys_rst = 1'b1;
    keep = 1'b0;
    repeat (10) @(posedge i_mclk);
    @(negedge i_mclk);
    i_sys_rst = 1'b0;
    repeat (12) @(negedge i_mclk);
    check(g1, 8'hFA, "first_stage_gain_sel rst");
    check({2'b00, g2}, 8'h04, "second_stage_gain_sel rst");
    check({7'h00, direct}, 8'h01, "link rst");
    check(dac, 8'h80, "dac rst");
    rd(4'h1);
    check({7'h00, rd_mode}, 8'h00, "locked");
    check({7'h00, drove}, 8'h00, "no drive locked");
    for (int i = 0; i < 4; i++)
    begin
      v = {1'b1, 2'(i), i[0], i[1], 2'(i), i[0]};
      wr(4'h0, v);
      check(g1, i[0] ? 8'h2A : 8'hFA, "first_stage_gain_sel");
      check({2'b00, g2}, 8'h04 << i, "second_stage_gain_sel");
      check({6'h00, route, direct}, {6'h00, i[0], ~i[0]}, "route");
      check({7'h00, cm_sel}, {7'h00, i[1]}, "cm");
      check({1'b0, pwr, route, cm_sel, g2_sel, g1_sel}, {1'b0, v[6:0]},
            "fields");
    end
    wr(4'h1, 8'h37);
    check(dac, 8'h37, "dac");
    i_afe_spi_master.frame(8'h01, 8'hC3, 12, 1'b0, rdat);
    check(dac, 8'h37, "abort");
    wr(4'h1, 8'h5A);
    check(dac, 8'h5A, "after abort");
    i_afe_spi_master.frame(8'h11, 8'h99, 16, 1'b0, rdat);
    wr(4'h5, 8'h77);
    check(dac, 8'h5A, "ignored");
    wr(4'hF, 8'hFE);
    wr(4'hF, 8'h12);
    check({7'h00, rd_mode}, 8'h00, "bad key");
    wr(4'hF, 8'hFE);
    wr(4'hF, 8'hED);
    check({7'h00, rd_mode}, 8'h01, "key");
    rd(4'h0);
    check(rdat, 8'h7F, "rd cfg");
    rd(4'h1);
    check(rdat, 8'h5A, "rd dac");
    rd(4'h1);
    check(rdat, 8'h5A, "rd again");
    rd(4'hF);
    check(rdat, 8'h00, "rd key");
    keep = 1'b1;
    wr(4'h1, 8'hA5);
    wr(4'h0, 8'h01);
    rd(4'h1);
    check(rdat, 8'hA5, "2w rd");
    check(g1, 8'h2A, "2w cfg");
    keep = 1'b0;
    wr(4'hF, 8'h00);
    check({7'h00, rd_mode}, 8'h00, "relock");
    rd(4'h1);
    check(dac, 8'hA5, "dac kept");
    finish_test();
  end
endmodule // afe_spi_config_port_tb_top
